/* rtl/dma_regs_pkg.sv */
// Shared constants of the seven-channel DMA register block
package dma_regs_pkg;

  // Channel count and field widths
  localparam int NUM_CH = 7;
  localparam int COUNT_W = 16;
  localparam int ADDR_W = 8;

  // Register offsets (byte addresses)
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] CLEAR_OFF = 8'h04;
  localparam logic [7:0] CFG_OFF = 8'h08;
  localparam logic [7:0] COUNT_OFF = 8'h0C;
  localparam logic [7:0] PADDR_OFF = 8'h10;
  localparam logic [7:0] MADDR_OFF = 8'h14;
  localparam logic [7:0] CH_STRIDE = 8'h14;

  // Status and clear nibble layout, per channel at 4*(channel-1)
  localparam int FLAG_STRIDE = 4;
  localparam int FLAG_ANY = 0;
  localparam int FLAG_TC = 1;
  localparam int FLAG_HT = 2;
  localparam int FLAG_TE = 3;

  // Configuration field positions
  localparam int CFG_EN = 0;
  localparam int CFG_TC_IE = 1;
  localparam int CFG_HT_IE = 2;
  localparam int CFG_TE_IE = 3;
  localparam int CFG_DIR = 4;
  localparam int CFG_CIRC = 5;
  localparam int CFG_PINC = 6;
  localparam int CFG_MINC = 7;
  localparam int CFG_PSIZE = 8;
  localparam int CFG_MSIZE = 10;
  localparam int CFG_PRIO = 12;
  localparam int CFG_M2M = 14;
  localparam int CFG_W = 15;

  // Reset values
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;

  // Byte address of a per-channel register
  function automatic logic [7:0] chan_reg(input int c, input logic [7:0] rel);
    chan_reg = 8'(int'(rel) + c * int'(CH_STRIDE));
  endfunction

endpackage

/* rtl/dma_prio_arbiter.sv */
// Channel arbiter: software priority first, lower channel number on ties
`timescale 1ns/1ps
module dma_prio_arbiter #(
  parameter int NUM_CH = dma_regs_pkg::NUM_CH
) (
  // Requests and their priority levels
  input wire logic [NUM_CH-1:0] pend_i,
  input wire logic [2*NUM_CH-1:0] prio_i,
  // Winner
  output logic grant_any_o,
  output logic [2:0] grant_idx_o
);

  // Walk downward so that an equal level at a lower number takes over
  always_comb begin
    logic [1:0] best;
    best = 2'h0;
    grant_any_o = 1'b0;
    grant_idx_o = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_i[i] && (!grant_any_o || prio_i[2*i +: 2] >= best)) begin
        grant_any_o = 1'b1;
        grant_idx_o = 3'(i);
        best = prio_i[2*i +: 2];
      end
    end
  end

endmodule

/* rtl/dma_regs.sv */
// Register file, flag logic and item sequencer of the seven-channel DMA
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module dma_regs #(
  parameter int NUM_CH = dma_regs_pkg::NUM_CH,
  parameter int COUNT_W = dma_regs_pkg::COUNT_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Peripheral requests
  input wire logic [NUM_CH-1:0] req_i,
  // Item transfer port
  output logic xfer_valid_o,
  output logic [2:0] xfer_chan_o,
  output logic [31:0] xfer_src_o,
  output logic [31:0] xfer_dst_o,
  output logic [1:0] xfer_src_size_o,
  output logic [1:0] xfer_dst_size_o,
  input wire logic xfer_done_i,
  input wire logic xfer_err_i,
  // Channel interrupts
  output logic [NUM_CH-1:0] irq_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_POST = 2'b11
  } seq_state_t;

  seq_state_t state;
  logic [dma_regs_pkg::CFG_W-1:0] cfg [NUM_CH];
  logic [COUNT_W-1:0] cnt_init [NUM_CH];
  logic [COUNT_W-1:0] cnt [NUM_CH];
  logic [31:0] pbase [NUM_CH];
  logic [31:0] mbase [NUM_CH];
  logic [31:0] pcur [NUM_CH];
  logic [31:0] mcur [NUM_CH];
  logic [NUM_CH-1:0] half_seen;
  logic [NUM_CH-1:0] flg_any, flg_tc, flg_ht, flg_te;
  logic [NUM_CH-1:0] ev_tc, ev_ht, ev_te;
  logic [NUM_CH-1:0] pend;
  logic [2*NUM_CH-1:0] prio;
  logic grant_any;
  logic [2:0] grant_idx;
  logic [2:0] cur;
  logic [31:0] next_rdata;
  logic clr_wr;

  assign clr_wr = wr_i && addr_i == dma_regs_pkg::CLEAR_OFF;

  // A channel competes only while enabled, with items left and a request or memory-to-memory mode
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pend[c] = cfg[c][dma_regs_pkg::CFG_EN] && cnt[c] != '0 &&
        (cfg[c][dma_regs_pkg::CFG_M2M] || req_i[c]);
      prio[2*c +: 2] = cfg[c][dma_regs_pkg::CFG_PRIO +: 2];
    end
  end

  dma_prio_arbiter #(
    .NUM_CH(NUM_CH)
  ) u_arb (
    .pend_i(pend),
    .prio_i(prio),
    .grant_any_o(grant_any),
    .grant_idx_o(grant_idx)
  );

  // Configuration; an error drops the enable so a faulty channel stops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg[c] <= dma_regs_pkg::CFG_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_i && addr_i == dma_regs_pkg::chan_reg(c,
            dma_regs_pkg::CFG_OFF)) begin
          cfg[c] <= wdata_i[dma_regs_pkg::CFG_W-1:0];
        end else if (ev_te[c]) begin
          cfg[c][dma_regs_pkg::CFG_EN] <= 1'b0;
        end
      end
    end
  end

  // Count and addresses: software loads them only while disabled
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cnt_init[c] <= '0;
        cnt[c] <= '0;
        pbase[c] <= dma_regs_pkg::REG_RESET;
        mbase[c] <= dma_regs_pkg::REG_RESET;
        pcur[c] <= dma_regs_pkg::REG_RESET;
        mcur[c] <= dma_regs_pkg::REG_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!cfg[c][dma_regs_pkg::CFG_EN] && wr_i) begin
          if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::COUNT_OFF)) begin
            cnt_init[c] <= wdata_i[COUNT_W-1:0];
            cnt[c] <= wdata_i[COUNT_W-1:0];
          end
          if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::PADDR_OFF)) begin
            pbase[c] <= wdata_i;
            pcur[c] <= wdata_i;
          end
          if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::MADDR_OFF)) begin
            mbase[c] <= wdata_i;
            mcur[c] <= wdata_i;
          end
        end
      end
      if (state == ST_BUSY && xfer_done_i && !xfer_err_i) begin
        if (cnt[cur] == COUNT_W'(1) && cfg[cur][dma_regs_pkg::CFG_CIRC]) begin
          cnt[cur] <= cnt_init[cur];
          pcur[cur] <= pbase[cur];
          mcur[cur] <= mbase[cur];
        end else begin
          cnt[cur] <= cnt[cur] - COUNT_W'(1);
          if (cfg[cur][dma_regs_pkg::CFG_PINC]) begin
            pcur[cur] <= pcur[cur] + step(cfg[cur][dma_regs_pkg::CFG_PSIZE +: 2]);
          end
          if (cfg[cur][dma_regs_pkg::CFG_MINC]) begin
            mcur[cur] <= mcur[cur] + step(cfg[cur][dma_regs_pkg::CFG_MSIZE +: 2]);
          end
        end
      end
    end
  end

  // Bytes per item; reserved size code is treated as a word
  function automatic logic [31:0] step(input logic [1:0] sz);
    step = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
  endfunction

  // Low address bits below the item size are ignored on the bus
  function automatic logic [31:0] align(input logic [31:0] a,
                                        input logic [1:0] sz);
    align = a & ~(step(sz) - 32'h1);
  endfunction

  // Sequencer: arbitrate, hand one item out, wait, let counts settle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cur <= 3'h0;
      xfer_valid_o <= 1'b0;
      xfer_chan_o <= 3'h0;
      xfer_src_o <= 32'h0;
      xfer_dst_o <= 32'h0;
      xfer_src_size_o <= 2'h0;
      xfer_dst_size_o <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (grant_any) begin
            cur <= grant_idx;
            xfer_valid_o <= 1'b1;
            xfer_chan_o <= grant_idx;
            if (cfg[grant_idx][dma_regs_pkg::CFG_DIR]) begin
              xfer_src_o <= align(mcur[grant_idx],
                cfg[grant_idx][dma_regs_pkg::CFG_MSIZE +: 2]);
              xfer_dst_o <= align(pcur[grant_idx],
                cfg[grant_idx][dma_regs_pkg::CFG_PSIZE +: 2]);
              xfer_src_size_o <= cfg[grant_idx][dma_regs_pkg::CFG_MSIZE +: 2];
              xfer_dst_size_o <= cfg[grant_idx][dma_regs_pkg::CFG_PSIZE +: 2];
            end else begin
              xfer_src_o <= align(pcur[grant_idx],
                cfg[grant_idx][dma_regs_pkg::CFG_PSIZE +: 2]);
              xfer_dst_o <= align(mcur[grant_idx],
                cfg[grant_idx][dma_regs_pkg::CFG_MSIZE +: 2]);
              xfer_src_size_o <= cfg[grant_idx][dma_regs_pkg::CFG_PSIZE +: 2];
              xfer_dst_size_o <= cfg[grant_idx][dma_regs_pkg::CFG_MSIZE +: 2];
            end
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (xfer_done_i || xfer_err_i) begin
            xfer_valid_o <= 1'b0;
            state <= ST_POST;
          end
        end
        ST_POST: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Item events as one-cycle pulses
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_tc <= '0;
      ev_ht <= '0;
      ev_te <= '0;
      half_seen <= '0;
    end else begin
      ev_tc <= '0;
      ev_ht <= '0;
      ev_te <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_i && addr_i == dma_regs_pkg::chan_reg(c,
            dma_regs_pkg::COUNT_OFF) && !cfg[c][dma_regs_pkg::CFG_EN]) begin
          half_seen[c] <= 1'b0;
        end
      end
      if (state == ST_BUSY && xfer_err_i) begin
        ev_te[cur] <= 1'b1;
      end else if (state == ST_BUSY && xfer_done_i) begin
        if (!half_seen[cur] &&
            cnt[cur] - COUNT_W'(1) <= (cnt_init[cur] >> 1)) begin
          ev_ht[cur] <= 1'b1;
          half_seen[cur] <= 1'b1;
        end
        if (cnt[cur] == COUNT_W'(1)) begin
          ev_tc[cur] <= 1'b1;
          half_seen[cur] <= 1'b0;
        end
      end
    end
  end

  // Flags: an event in the clearing cycle survives the clear
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flg_any <= '0;
      flg_tc <= '0;
      flg_ht <= '0;
      flg_te <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        logic all_clr;
        all_clr = clr_wr && wdata_i[4*c + dma_regs_pkg::FLAG_ANY];
        flg_any[c] <= (flg_any[c] && !all_clr) ||
          ev_tc[c] || ev_ht[c] || ev_te[c];
        flg_tc[c] <= (flg_tc[c] && !all_clr && !(clr_wr &&
          wdata_i[4*c + dma_regs_pkg::FLAG_TC])) || ev_tc[c];
        flg_ht[c] <= (flg_ht[c] && !all_clr && !(clr_wr &&
          wdata_i[4*c + dma_regs_pkg::FLAG_HT])) || ev_ht[c];
        flg_te[c] <= (flg_te[c] && !all_clr && !(clr_wr &&
          wdata_i[4*c + dma_regs_pkg::FLAG_TE])) || ev_te[c];
      end
    end
  end

  // Interrupt lines, one per channel
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        irq_o[c] <= (flg_tc[c] && cfg[c][dma_regs_pkg::CFG_TC_IE]) ||
          (flg_ht[c] && cfg[c][dma_regs_pkg::CFG_HT_IE]) ||
          (flg_te[c] && cfg[c][dma_regs_pkg::CFG_TE_IE]);
      end
    end
  end

  // Read decode; clear register and unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0;
    if (addr_i == dma_regs_pkg::STATUS_OFF) begin
      for (int c = 0; c < NUM_CH; c++) begin
        next_rdata[4*c +: 4] = {flg_te[c], flg_ht[c], flg_tc[c], flg_any[c]};
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::CFG_OFF)) begin
        next_rdata = {17'h0, cfg[c]};
      end
      if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::COUNT_OFF)) begin
        next_rdata = {16'h0, cnt[c]};
      end
      if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::PADDR_OFF)) begin
        next_rdata = pbase[c];
      end
      if (addr_i == dma_regs_pkg::chan_reg(c, dma_regs_pkg::MADDR_OFF)) begin
        next_rdata = mbase[c];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= dma_regs_pkg::REG_RESET;
    end else begin
      rdata_o <= rd_i ? next_rdata : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence item_taken;
    state == ST_BUSY && xfer_done_i && !xfer_err_i;
  endsequence

  sequence last_item;
    item_taken ##0 cnt[cur] == COUNT_W'(1);
  endsequence

  tc_flag_set_a: assert property (last_item |-> ##2 flg_tc[$past(cur, 2)])
    else $error("complete flag not set after last item");
  any_flag_set_a: assert property ((|(ev_tc | ev_ht | ev_te)) |=>
    ((flg_any & $past(ev_tc | ev_ht | ev_te)) == $past(ev_tc | ev_ht | ev_te)))
    else $error("global flag missing after event");
  err_flag_set_a: assert property (state == ST_BUSY && xfer_err_i |->
    ##2 flg_te[$past(cur, 2)])
    else $error("error flag not set after error");
  all_clear_a: assert property (clr_wr && wdata_i[0] && !ev_tc[0] && !ev_ht[0]
    && !ev_te[0] |=> !flg_any[0] && !flg_tc[0] && !flg_ht[0] && !flg_te[0])
    else $error("global clear left a flag set");
  status_ro_a: assert property (wr_i && addr_i == dma_regs_pkg::STATUS_OFF
    |=> (flg_tc | $past(flg_tc)) == ($past(flg_tc) | $past(ev_tc)))
    else $error("status write changed flags");
  irq_follow_a: assert property ((flg_tc[0] && cfg[0][dma_regs_pkg::CFG_TC_IE])
    |=> irq_o[0])
    else $error("interrupt line missing");
  zero_count_a: assert property ($rose(xfer_valid_o) |->
    $past(cnt[grant_idx] != '0 && cfg[grant_idx][dma_regs_pkg::CFG_EN]))
    else $error("transfer started on empty or disabled channel");
  circ_reload_a: assert property (last_item ##0 cfg[cur][dma_regs_pkg::CFG_CIRC]
    |=> cnt[$past(cur)] == cnt_init[$past(cur)])
    else $error("circular count not reloaded");
  minc_step_a: assert property (item_taken ##0 cnt[cur] != COUNT_W'(1)
    ##0 cfg[cur][dma_regs_pkg::CFG_MINC] |=> mcur[$past(cur)] ==
    $past(mcur[cur]) + step($past(cfg[cur][dma_regs_pkg::CFG_MSIZE +: 2])))
    else $error("memory address step wrong");

endmodule

/* verif/dma_item_responder.sv */
// Far-side model that answers item transfers after a set latency
`timescale 1ns/1ps
module dma_item_responder (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Item request and behaviour controls
  input wire logic xfer_valid_i,
  input wire logic [7:0] lat_i,
  input wire logic fail_i,
  // Item answers
  output logic done_o,
  output logic err_o
);
  logic [7:0] cnt;

  // Answers are one-cycle pulses; the wait restarts whenever valid drops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 8'h00;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      if (xfer_valid_i && !done_o && !err_o) begin
        if (cnt >= lat_i) begin
          cnt <= 8'h00;
          done_o <= !fail_i;
          err_o <= fail_i;
        end else begin
          cnt <= cnt + 8'h01;
        end
      end else begin
        cnt <= 8'h00;
      end
    end
  end
endmodule

/* verif/seven_channel_dma_regs_tb.sv */
// Self-checking bench for the seven-channel DMA register block
`timescale 1ns/1ps
module seven_channel_dma_regs_tb;
  logic mclk_i, rstn_i, bus_wr, bus_rd, fail, done, err, xv;
  logic [7:0] bus_addr, lat;
  logic [31:0] bus_wdata, rdata, src, dst;
  logic [6:0] req, irq;
  logic [2:0] chan;
  logic [1:0] ssz, dsz;
  logic [31:0] q_src[$], q_dst[$], q_inf[$];
  int error_cnt, num_checks;

  dma_regs dma_regs_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .addr_i(bus_addr), .wdata_i(bus_wdata), .wr_i(bus_wr), .rd_i(bus_rd),
    .rdata_o(rdata), .req_i(req), .xfer_valid_o(xv), .xfer_chan_o(chan),
    .xfer_src_o(src), .xfer_dst_o(dst), .xfer_src_size_o(ssz),
    .xfer_dst_size_o(dsz), .xfer_done_i(done), .xfer_err_i(err),
    .irq_o(irq));
  dma_item_responder dma_item_responder_inst (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .xfer_valid_i(xv), .lat_i(lat), .fail_i(fail),
    .done_o(done), .err_o(err));

  always #5 mclk_i = ~mclk_i;

  // Log every item at the edge that ends it
  always @(posedge mclk_i) begin
    if (xv === 1'b1 && (done === 1'b1 || err === 1'b1)) begin
      q_src.push_back(src);
      q_dst.push_back(dst);
      q_inf.push_back({25'h0, chan, ssz, dsz});
    end
  end

  function automatic logic [7:0] ca(input int n, input logic [7:0] rel);
    ca = rel + 8'(20 * n);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk_i);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk_i);
    bus_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic items(input int n);
    for (int i = 0; i < 400 && q_src.size() < n; i++) @(posedge mclk_i);
    chk(32'(q_src.size()), 32'(n));
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic ick(input int k, input logic [2:0] c, input logic [1:0] s,
                     input logic [1:0] d, input logic [31:0] sa,
                     input logic [31:0] da);
    chk(q_inf[k], {25'h0, c, s, d});
    chk(q_src[k], sa);
    chk(q_dst[k], da);
  endtask

  task automatic flush();
    q_src.delete();
    q_dst.delete();
    q_inf.delete();
  endtask

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial begin
    mclk_i = 0; rstn_i = 0; bus_wr = 0; bus_rd = 0; bus_addr = 8'h00;
    bus_wdata = 32'h0; req = 7'h00; lat = 8'd20; fail = 0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h90, 32'h0);
    for (int n = 0; n < 7; n++) begin
      rchk(ca(n, 8'h08), 32'h0);
      wr(ca(n, 8'h08), 32'hFFFF_FFFE);
      rchk(ca(n, 8'h08), 32'h0000_7FFE);
      wr(ca(n, 8'h0C), 32'h1234_0000 | 32'(n + 1));
      wr(ca(n, 8'h10), 32'hA000_0000 | 32'(n));
      wr(ca(n, 8'h14), 32'hB000_0000 | 32'(n));
      rchk(ca(n, 8'h0C), 32'(n + 1));
      rchk(ca(n, 8'h10), 32'hA000_0000 | 32'(n));
      rchk(ca(n, 8'h14), 32'hB000_0000 | 32'(n));
      wr(ca(n, 8'h0C), 32'h0);
      wr(ca(n, 8'h08), 32'h0);
    end
    // Enabled but zero count must stay idle
    wr(8'h08, 32'h0000_4001);
    repeat (20) @(posedge mclk_i);
    chk(32'(q_src.size()), 32'h0);
    wr(8'h08, 32'h0);
    // Memory to peripheral, 8-bit source and 32-bit destination
    wr(8'h0C, 32'h4);
    wr(8'h10, 32'h100);
    wr(8'h14, 32'h200);
    wr(8'h08, 32'h0000_42D7);
    items(2);
    rchk(8'h00, 32'h5);
    rchk(8'h0C, 32'h2);
    chk({25'h0, irq}, 32'h1);
    items(4);
    for (int k = 0; k < 4; k++) begin
      ick(k, 3'd0, 2'd0, 2'd2, 32'h200 + k, 32'h100 + 4 * k);
    end
    rchk(8'h00, 32'h7);
    rchk(8'h0C, 32'h0);
    wr(8'h04, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rchk(8'h00, 32'h5);
    chk({25'h0, irq}, 32'h1);
    wr(8'h08, 32'h0000_42D2);
    rchk(8'h08, 32'h0000_42D2);
    chk({25'h0, irq}, 32'h0);
    wr(8'h04, 32'h1);
    rchk(8'h00, 32'h0);
    // Error on channel 2
    flush();
    fail <= 1'b1;
    lat <= 8'd3;
    wr(ca(1, 8'h0C), 32'h3);
    wr(ca(1, 8'h08), 32'h0000_4009);
    items(1);
    fail <= 1'b0;
    rchk(8'h00, 32'h90);
    chk({25'h0, irq}, 32'h2);
    rchk(ca(1, 8'h0C), 32'h3);
    wr(8'h04, 32'h80);
    rchk(8'h00, 32'h10);
    wr(8'h04, 32'h10);
    rchk(8'h00, 32'h0);
    // Circular on channel 3, peripheral to memory, 16-bit items
    flush();
    wr(ca(2, 8'h0C), 32'h2);
    wr(ca(2, 8'h10), 32'h300);
    wr(ca(2, 8'h14), 32'h400);
    wr(ca(2, 8'h08), 32'h0000_4561);
    items(4);
    wr(ca(2, 8'h08), 32'h0);
    for (int k = 0; k < 4; k++) begin
      ick(k, 3'd2, 2'd1, 2'd1, 32'h300 + 2 * (k % 2), 32'h400);
    end
    repeat (40) @(posedge mclk_i);
    wr(8'h04, 32'h100);
    // Arbitration: equal priority, then channel 5 raised
    for (int r = 0; r < 2; r++) begin
      flush();
      for (int n = 3; n < 6; n++) wr(ca(n, 8'h0C), 32'h1);
      wr(ca(3, 8'h08), 32'h1);
      wr(ca(4, 8'h08), (r == 1) ? 32'h2001 : 32'h1);
      @(posedge mclk_i);
      req <= 7'h38;
      items(2);
      repeat (20) @(posedge mclk_i);
      chk(32'(q_src.size()), 32'h2);
      chk(32'(q_inf[0][6:4]), (r == 1) ? 32'h4 : 32'h3);
      ick(1, (r == 1) ? 3'd3 : 3'd4, 2'd0, 2'd0, 32'hA000_0000 + 4 - r,
          32'hB000_0000 + 4 - r);
      @(posedge mclk_i);
      req <= 7'h00;
      wr(ca(3, 8'h08), 32'h0);
      wr(ca(4, 8'h08), 32'h0);
    end
    final_report();
  end
endmodule
